// *** inc/jbst_pkg.sv ***
// constants, state type and instruction codes of the boundary scan test port
// assumes one system clock samples the whole test port; no imports anywhere
package jbst_pkg;
	// system clock period, figure in ns
	localparam int CLK_NS = 20;
	// synchroniser depth for every pin that crosses into the clock domain
	localparam int SYNC_STAGES = 2;
	// instruction register width and its codes
	localparam int IR_W = 3;
	localparam logic [2:0] IR_EXTEST = 3'h0;
	localparam logic [2:0] IR_SAMPLE = 3'h4;
	localparam logic [2:0] IR_IDCODE = 3'h6;
	localparam logic [2:0] IR_BYPASS = 3'h7;
	// value parked in the instruction shifter at capture-ir
	localparam logic [2:0] IR_CAPTURE = 3'h1;
	// instruction loaded while the port sits in test-logic-reset
	localparam logic [2:0] IR_RESET = IR_IDCODE;
	// data register lengths
	localparam int ID_W = 32;
	localparam int SCAN_W = 98;
	// identification word field positions and widths
	localparam int ID_MARK_BIT = 0;
	localparam int ID_PRODUCER_LSB = 1;
	localparam int ID_PRODUCER_W = 11;
	localparam int ID_PART_LSB = 12;
	localparam int ID_PART_W = 16;
	localparam int ID_REV_LSB = 28;
	localparam int ID_REV_W = 4;
	// arbitrary neutral identity values, not those of any real part
	localparam logic [10:0] ID_PRODUCER_DEF = 11'h055;
	localparam logic [15:0] ID_PART_DEF = 16'h1234;
	localparam logic [3:0] ID_REV_DEF = 4'h1;
	// bypass cell content captured at capture-dr
	localparam logic BYPASS_CAPTURE = 1'b0;
	// the sixteen controller states
	typedef enum logic [3:0] {
		st_reset, st_idle,
		st_sel_dr, st_cap_dr, st_shift_dr, st_exit1_dr, st_pause_dr, st_exit2_dr, st_upd_dr,
		st_sel_ir, st_cap_ir, st_shift_ir, st_exit1_ir, st_pause_ir, st_exit2_ir, st_upd_ir
	} jbst_state_t;
endpackage

// *** inc/jbst_tap_if.sv ***
// signals shared between the test port core and its state controller
// assumes both ends run on the same system clock
`timescale 1ns/10ps
interface jbst_tap_if;
	logic tck_rise; // one-cycle pulse, test clock rose
	logic tck_fall; // one-cycle pulse, test clock fell
	logic tms; // synchronised mode select
	jbst_pkg::jbst_state_t state; // controller state
	modport core (output tck_rise, output tck_fall, output tms, input state);
	modport ctrl (input tck_rise, input tms, output state);
endinterface

// *** verilog/jbst_sync.sv ***
// plain two-stage level synchroniser, any width
// assumes the input is a level from outside the clk domain
`timescale 1ns/10ps
module jbst_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	// first stage, read only by the second stage
	logic [W-1:0] meta;

	generate
		if (W < 1) begin : g_bad_w
			$error("jbst_sync width must be at least one");
		end
	endgenerate

	// two flops, reset to zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule // jbst_sync

// *** verilog/jbst_fsm.sv ***
// sixteen-state test port controller, advanced on each test clock rise
// assumes tck_rise and tms arrive already synchronised
`timescale 1ns/10ps
module jbst_fsm (
	input wire logic clk,
	input wire logic rst,
	jbst_tap_if.ctrl tap
);
	jbst_pkg::jbst_state_t state;
	jbst_pkg::jbst_state_t next_state;

	// standard transition table; only mode select steers it
	always_comb begin
		next_state = state;
		case (state)
			jbst_pkg::st_reset: next_state = tap.tms ? jbst_pkg::st_reset : jbst_pkg::st_idle;
			jbst_pkg::st_idle: next_state = tap.tms ? jbst_pkg::st_sel_dr : jbst_pkg::st_idle;
			jbst_pkg::st_sel_dr: next_state = tap.tms ? jbst_pkg::st_sel_ir : jbst_pkg::st_cap_dr;
			jbst_pkg::st_cap_dr: next_state = tap.tms ? jbst_pkg::st_exit1_dr : jbst_pkg::st_shift_dr;
			jbst_pkg::st_shift_dr: next_state = tap.tms ? jbst_pkg::st_exit1_dr : jbst_pkg::st_shift_dr;
			jbst_pkg::st_exit1_dr: next_state = tap.tms ? jbst_pkg::st_upd_dr : jbst_pkg::st_pause_dr;
			jbst_pkg::st_pause_dr: next_state = tap.tms ? jbst_pkg::st_exit2_dr : jbst_pkg::st_pause_dr;
			jbst_pkg::st_exit2_dr: next_state = tap.tms ? jbst_pkg::st_upd_dr : jbst_pkg::st_shift_dr;
			jbst_pkg::st_upd_dr: next_state = tap.tms ? jbst_pkg::st_sel_dr : jbst_pkg::st_idle;
			jbst_pkg::st_sel_ir: next_state = tap.tms ? jbst_pkg::st_reset : jbst_pkg::st_cap_ir;
			jbst_pkg::st_cap_ir: next_state = tap.tms ? jbst_pkg::st_exit1_ir : jbst_pkg::st_shift_ir;
			jbst_pkg::st_shift_ir: next_state = tap.tms ? jbst_pkg::st_exit1_ir : jbst_pkg::st_shift_ir;
			jbst_pkg::st_exit1_ir: next_state = tap.tms ? jbst_pkg::st_upd_ir : jbst_pkg::st_pause_ir;
			jbst_pkg::st_pause_ir: next_state = tap.tms ? jbst_pkg::st_exit2_ir : jbst_pkg::st_pause_ir;
			jbst_pkg::st_exit2_ir: next_state = tap.tms ? jbst_pkg::st_upd_ir : jbst_pkg::st_shift_ir;
			jbst_pkg::st_upd_ir: next_state = tap.tms ? jbst_pkg::st_sel_dr : jbst_pkg::st_idle;
			default: next_state = jbst_pkg::st_reset;
		endcase
	end

	// state only moves on a test clock rise
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= jbst_pkg::st_reset;
		end else if (tap.tck_rise) begin
			state <= next_state;
		end
	end

	assign tap.state = state;
endmodule // jbst_fsm

// *** verilog/jbst_tap.sv ***
// boundary scan test access port: instruction register, decode, and the
// pin scan chain, identification and single-bit bypass data registers
// assumes tck, tms, tdi and pin_in are asynchronous pins; core_out is on clk
`timescale 1ns/10ps
module jbst_tap #(
	parameter int SCAN_W = jbst_pkg::SCAN_W,
	parameter logic [10:0] ID_PRODUCER = jbst_pkg::ID_PRODUCER_DEF,
	parameter logic [15:0] ID_PART = jbst_pkg::ID_PART_DEF,
	parameter logic [3:0] ID_REV = jbst_pkg::ID_REV_DEF
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe,
	input wire logic [SCAN_W-1:0] pin_in,
	input wire logic [SCAN_W-1:0] core_out,
	output logic [SCAN_W-1:0] pin_out,
	output logic extest_active
);
	// refuse chain lengths the shifter cannot serve
	generate
		if (SCAN_W < 2) begin : g_bad_scan
			$error("jbst_tap scan chain must be at least two bits");
		end
	endgenerate

	// ---------------------------------------------------------------
	// pin synchronisation and test clock edges
	// ---------------------------------------------------------------

	// test pins after two flops, kept together so they stay aligned
	logic [2:0] tpin_sync;
	// pin_in after two flops
	logic [SCAN_W-1:0] pin_sync;
	// previous synchronised tck, for edge finding
	logic tck_prev;

	// carrier between core and controller
	jbst_tap_if tap ();

	// tck, tms and tdi share one synchroniser so their skew is equal
	jbst_sync #(
		.W(3)
	) u_tpin_sync (
		.clk(clk),
		.rst(rst),
		.d({tck, tms, tdi}),
		.q(tpin_sync)
	);

	// pin values seen by capture-dr
	jbst_sync #(
		.W(SCAN_W)
	) u_pin_sync (
		.clk(clk),
		.rst(rst),
		.d(pin_in),
		.q(pin_sync)
	);

	// named views of the synchronised test pins
	wire tck_s = tpin_sync[2];
	wire tms_s = tpin_sync[1];
	wire tdi_s = tpin_sync[0];

	// remember tck for edge detection
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tck_prev <= 1'b0;
		end else begin
			tck_prev <= tck_s;
		end
	end

	// edges of the test clock; the controller and test registers move at its rate
	assign tap.tck_rise = tck_s & ~tck_prev;
	assign tap.tck_fall = ~tck_s & tck_prev;
	assign tap.tms = tms_s;

	// the sixteen-state controller
	jbst_fsm u_fsm (
		.clk(clk),
		.rst(rst),
		.tap(tap.ctrl)
	);

	// short names for the controller outputs
	wire rise = tap.tck_rise;
	wire fall = tap.tck_fall;
	wire st_reset = (tap.state == jbst_pkg::st_reset);
	wire st_cap_dr = (tap.state == jbst_pkg::st_cap_dr);
	wire st_shift_dr = (tap.state == jbst_pkg::st_shift_dr);
	wire st_upd_dr = (tap.state == jbst_pkg::st_upd_dr);
	wire st_cap_ir = (tap.state == jbst_pkg::st_cap_ir);
	wire st_shift_ir = (tap.state == jbst_pkg::st_shift_ir);
	wire st_upd_ir = (tap.state == jbst_pkg::st_upd_ir);

	// ---------------------------------------------------------------
	// instruction register
	// ---------------------------------------------------------------

	// shifting stage of the instruction register
	logic [jbst_pkg::IR_W-1:0] ir_shift;
	// current instruction, changes only at update-ir or reset
	logic [jbst_pkg::IR_W-1:0] ir;

	// capture loads the fixed pattern, shift takes tdi at the top so
	// the first bit in ends up in bit zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ir_shift <= jbst_pkg::IR_CAPTURE;
		end else if (rise && st_cap_ir) begin
			ir_shift <= jbst_pkg::IR_CAPTURE;
		end else if (rise && st_shift_ir) begin
			ir_shift <= {tdi_s, ir_shift[jbst_pkg::IR_W-1:1]};
		end
	end

	// update on the falling edge in update-ir, as the standard port does,
	// so the new instruction is stable before the next rise
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ir <= jbst_pkg::IR_RESET;
		end else if (st_reset) begin
			ir <= jbst_pkg::IR_RESET; // leaving test mode drops extest
		end else if (fall && st_upd_ir) begin
			ir <= ir_shift;
		end
	end

	// ---------------------------------------------------------------
	// instruction decode
	// ---------------------------------------------------------------

	// which data register sits between tdi and tdo
	wire sel_extest = (ir == jbst_pkg::IR_EXTEST);
	wire sel_sample = (ir == jbst_pkg::IR_SAMPLE);
	wire sel_idcode = (ir == jbst_pkg::IR_IDCODE);
	wire sel_scan = sel_extest | sel_sample;
	// bypass covers 111 and every code not listed above
	wire sel_bypass = ~sel_scan & ~sel_idcode;

	// ---------------------------------------------------------------
	// data registers
	// ---------------------------------------------------------------

	// pin scan chain shifter and its update latch
	logic [SCAN_W-1:0] pin_scan_chain;
	logic [SCAN_W-1:0] scan_update;
	// identification shifter
	logic [jbst_pkg::ID_W-1:0] device_ident_reg;
	// one-bit bypass path
	logic single_bit_passthrough;

	// identification word assembled from its fields
	wire [jbst_pkg::ID_W-1:0] ident_word = {ID_REV, ID_PART, ID_PRODUCER, 1'b1};

	// scan chain: capture the pin values, then shift toward bit zero.
	// capture takes pin_in for every cell; under sample that is the
	// present level of inputs and of driven outputs alike
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_scan_chain <= '0;
		end else if (rise && st_cap_dr && sel_scan) begin
			pin_scan_chain <= pin_sync;
		end else if (rise && st_shift_dr && sel_scan) begin
			pin_scan_chain <= {tdi_s, pin_scan_chain[SCAN_W-1:1]};
		end
	end

	// update latch: loaded under both scan instructions so that preload
	// works, but only drives pins under extest
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			scan_update <= '0;
		end else if (fall && st_upd_dr && sel_scan) begin
			scan_update <= pin_scan_chain;
		end
	end

	// identification shifter, low bit leaves first
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			device_ident_reg <= '0;
		end else if (rise && st_cap_dr && sel_idcode) begin
			device_ident_reg <= ident_word;
		end else if (rise && st_shift_dr && sel_idcode) begin
			device_ident_reg <= {tdi_s, device_ident_reg[jbst_pkg::ID_W-1:1]};
		end
	end

	// single bypass cell: one tck of delay from tdi to tdo
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			single_bit_passthrough <= 1'b0;
		end else if (rise && st_cap_dr && sel_bypass) begin
			single_bit_passthrough <= jbst_pkg::BYPASS_CAPTURE;
		end else if (rise && st_shift_dr && sel_bypass) begin
			single_bit_passthrough <= tdi_s;
		end
	end

	// ---------------------------------------------------------------
	// serial output
	// ---------------------------------------------------------------

	// bit offered on tdo, chosen by the current instruction
	wire dr_out = sel_scan ? pin_scan_chain[0] :
		sel_idcode ? device_ident_reg[0] :
		single_bit_passthrough;
	wire next_tdo = st_shift_ir ? ir_shift[0] : dr_out;
	wire next_tdo_oe = st_shift_ir | st_shift_dr;

	// tdo changes on the falling test clock edge, so the controller
	// samples a settled bit at its next rise; tdo_oe floats the pin
	// outside the shift states
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tdo <= 1'b0;
			tdo_oe <= 1'b0;
		end else if (fall) begin
			tdo <= next_tdo;
			tdo_oe <= next_tdo_oe;
		end
	end

	// ---------------------------------------------------------------
	// pin drive
	// ---------------------------------------------------------------

	// per-cell selection between core logic and the scan pattern
	logic [SCAN_W-1:0] next_pin_out;
	genvar gi;
	generate
		for (gi = 0; gi < SCAN_W; gi++) begin : g_cell
			// extest takes the pin, everything else keeps the core path
			assign next_pin_out[gi] = sel_extest ? scan_update[gi] : core_out[gi];
		end
	endgenerate

	// registered pin drive; costs one clk of latency on the core path
	// but keeps the outputs glitch free when the instruction changes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_out <= '0;
			extest_active <= 1'b0;
		end else begin
			pin_out <= next_pin_out;
			extest_active <= sel_extest;
		end
	end
endmodule // jbst_tap

// *** testbench/jbst_tap_chk.sv ***
// concurrent checks on the pins of the boundary scan test port
// assumes tck phases last at least three clk and rst is asynchronous
`timescale 1ns/10ps
module jbst_tap_chk #(
	parameter int SCAN_W = 98
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic tdo,
	input wire logic tdo_oe,
	input wire logic [SCAN_W-1:0] pin_in,
	input wire logic [SCAN_W-1:0] core_out,
	input wire logic [SCAN_W-1:0] pin_out,
	input wire logic extest_active
);
	logic tck_q; // tck one clk ago
	logic [4:0] since_fall; // clk since a tck fall, saturating
	logic [4:0] since_rise; // clk since a tck rise, saturating
	logic [2:0] ones; // rises in a row with tms high, stops at five
	wire fall_w = tck_q & ~tck;
	wire rise_w = ~tck_q & tck;
	wire [4:0] next_fall = fall_w ? 5'h00 : since_fall + {4'h0, since_fall != 5'h1f};
	wire [4:0] next_rise = rise_w ? 5'h00 : since_rise + {4'h0, since_rise != 5'h1f};
	wire [2:0] next_ones = !rise_w ? ones : (!tms ? 3'h0 : ones + {2'h0, ones != 3'h5});
	// edge-distance counters start saturated: no edge is assumed before the first real one
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tck_q <= 1'b0;
			since_fall <= 5'h1f;
			since_rise <= 5'h1f;
			ones <= 3'h0;
		end else begin
			tck_q <= tck;
			since_fall <= next_fall;
			since_rise <= next_rise;
			ones <= next_ones;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// window in which a tck fall may show at the outputs
	sequence upd_win_s;
		since_fall inside {[5'h01:5'h06]};
	endsequence
	// entering test-logic-reset needs three or more high mode-select rises;
	// the instruction reload then lands shortly after that rise
	sequence tlr_entry_s;
		ones >= 3'h3 && since_rise inside {[5'h01:5'h06]};
	endsequence
	// five high mode-select rises, then settled
	sequence tlr_s;
		ones == 3'h5 && since_rise == 5'h06;
	endsequence
	reset_vals_a: assert property ($fell(rst) |-> !tdo && !tdo_oe && !extest_active && pin_out == '0)
		else $error("outputs not at reset values");
	pin_follow_a: assert property (!extest_active && !$past(extest_active) && !$past(rst)
		|-> pin_out == $past(core_out)) else $error("pin drive lost the core path");
	tdo_edge_a: assert property ($changed(tdo) |-> upd_win_s)
		else $error("serial out moved away from a tck fall");
	oe_edge_a: assert property ($changed(tdo_oe) |-> upd_win_s)
		else $error("serial enable moved away from a tck fall");
	inst_edge_a: assert property ($changed(extest_active) |-> upd_win_s or tlr_entry_s)
		else $error("instruction changed away from a tck fall");
	pin_update_a: assert property (extest_active && $past(extest_active) && $changed(pin_out)
		|-> upd_win_s) else $error("test pattern reached pins off update");
	tlr_clear_a: assert property (tlr_s |-> !extest_active && !tdo_oe)
		else $error("test logic reset left the port active");
	quiet_hold_a: assert property (since_fall > 5'h08 && since_rise > 5'h08
		|-> $stable(tdo) && $stable(tdo_oe) && $stable(extest_active)) else $error("outputs moved without tck");
endmodule // jbst_tap_chk

bind jbst_tap jbst_tap_chk #(.SCAN_W(SCAN_W)) u_jbst_tap_chk (.clk(clk), .rst(rst), .tck(tck), .tms(tms),
	.tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in), .core_out(core_out), .pin_out(pin_out),
	.extest_active(extest_active));

// *** testbench/jbst_tester.sv ***
// model of the external test controller driving tck, tms and tdi
// assumes one task call at a time; tck rests low outside frames
`timescale 1ns/10ps
module jbst_tester (
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo_line
);
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// one 160 ns period; tdo read late in the high phase, it stands fall to fall
	task automatic step(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#80 tck = 1'b1;
		#70 o = tdo_line;
		tdi = ~d; // flip long after the rise: a late sampler takes the wrong bit
		#10 tck = 1'b0;
	endtask
	// five high rises reach reset, one low rise parks in idle
	task automatic go_reset();
		logic o;
		repeat (5) step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
	endtask
	// idle to shift, n bits low bit first, update, back to idle
	task automatic scan(input logic ir, input int n, input logic [127:0] din, output logic [127:0] dout);
		logic o;
		dout = '0;
		step(1'b1, 1'b0, o);
		if (ir) step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
		step(1'b0, 1'b0, o);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], o);
			dout[i] = o;
		end
		step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
	endtask
endmodule // jbst_tester

// *** testbench/tb.sv ***
// self-checking bench for the boundary scan test port
// assumes the tester model drives the link; core and pin levels change on negedge
`timescale 1ns/10ps
module tb;
	// arbitrary identity values
	localparam logic [10:0] T_PROD = 11'h2a5;
	localparam logic [15:0] T_PART = 16'h5a3c;
	localparam logic [3:0] T_REV = 4'h9;
	localparam logic [127:0] M100 = {28'h000_0000, {100{1'b1}}};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [97:0] pin_in = '0;
	logic [97:0] core_out = '0;
	logic [127:0] core_rnd; // fresh core drive each cycle
	wire tck, tms, tdi, tdo, tdo_oe, extest_active;
	wire [97:0] pin_out;
	wire tdo_line = tdo_oe ? tdo : 1'b1; // pull-up on the released line
	integer seed = 32'hdf5a_1ec5;
	int fails = 0;
	int n_checks = 0;
	jbst_tap #(.ID_PRODUCER(T_PROD), .ID_PART(T_PART), .ID_REV(T_REV)) u_jbst_tap (.clk(clk), .rst(rst),
		.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in), .core_out(core_out),
		.pin_out(pin_out), .extest_active(extest_active));
	jbst_tester u_jbst_tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo_line(tdo_line));
	initial forever #10 clk = ~clk;
	function automatic logic [127:0] rnd128();
		return {$random(seed), $random(seed), $random(seed), $random(seed)};
	endfunction
	// what a 100-bit data scan returns for a given instruction
	function automatic logic [127:0] exp_dr(input logic [2:0] code, input logic [127:0] din, input logic [97:0] pins);
		case (code)
			3'h0, 3'h4: return {din[29:0], pins};
			3'h6: return {din[95:0], T_REV, T_PART, T_PROD, 1'b1};
			default: return {din[126:0], 1'b0};
		endcase
	endfunction
	task automatic check(input string name, input logic [127:0] seen, input logic [127:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// the core keeps changing so the pin path is exercised throughout
	always @(negedge clk) begin
		core_rnd = rnd128();
		core_out <= core_rnd[97:0];
	end
	// hang guard
	initial begin
		repeat (30000) @(posedge clk);
		fails++;
		give_verdict();
	end
	initial begin
		logic [127:0] din, dout, pat;
		repeat (12) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		repeat (3) @(posedge clk);
		// link edges start on a falling clk edge, clear of the sampling edge
		@(negedge clk);
		u_jbst_tester.go_reset();
		// identification is the instruction after reset
		din = rnd128();
		u_jbst_tester.scan(1'b0, 100, din, dout);
		check("reset_idcode", dout & M100, exp_dr(3'h6, din, pin_in) & M100);
		// every code, documented or not, with fresh pin levels
		for (int c = 0; c < 8; c++) begin
			@(negedge clk);
			pat = rnd128();
			pin_in = pat[97:0];
			u_jbst_tester.scan(1'b1, 3, {125'h0, c[2:0]}, dout);
			check("ir_capture", dout, 128'h1);
			din = rnd128();
			u_jbst_tester.scan(1'b0, 100, din, dout);
			check("dr_path", dout & M100, exp_dr(c[2:0], din, pin_in) & M100);
			check("extest_flag", 128'(extest_active), 128'(c == 0));
			if (c == 0) check("extest_pins", 128'(pin_out), 128'(din[99:2]));
		end
		// preload under sample, pins stay on the core path
		u_jbst_tester.scan(1'b1, 3, 128'h4, dout);
		pat = rnd128();
		u_jbst_tester.scan(1'b0, 98, pat, dout);
		@(negedge clk);
		check("preload_pins", 128'(pin_out), 128'(core_out));
		// switching to extest drives the preloaded pattern
		u_jbst_tester.scan(1'b1, 3, 128'h0, dout);
		@(negedge clk);
		check("extest_preload", 128'(pin_out), 128'(pat[97:0]));
		// quiet link under extest: outputs must hold without tck edges
		repeat (12) @(negedge clk);
		u_jbst_tester.go_reset();
		@(negedge clk);
		check("tlr_pins", 128'(pin_out), 128'(core_out));
		check("tlr_flag", 128'(extest_active), 128'h0);
		give_verdict();
	end
endmodule // tb
